// ### pchr_cfg.svh
/*
  Offsets, field positions, reset values and bus constants for the
  capability header register bank.
  Assumes inclusion by bare name from pchr_read_mux and pchr_regs.
*/
`ifndef PCHR_CFG_SVH
`define PCHR_CFG_SVH
`define PCHR_HDR_OFFSET 12'h040
`define PCHR_DCAP_OFFSET 12'h044
`define PCHR_CAPABILITY_IDENTIFIER_VALUE 8'h10
`define PCHR_NEXT_LSB 8
`define PCHR_VER_LSB 16
`define PCHR_VER_RESET 4'h2
`define PCHR_TYPE_LSB 20
`define PCHR_TYPE_UP 4'h5
`define PCHR_TYPE_DOWN 4'h6
`define PCHR_SLOT_BIT 24
`define PCHR_SLOT_RESET 1'b0
`define PCHR_MPS_RESET 3'h4
`define PCHR_TAG_BIT 5
`define PCHR_TAG_RESET 1'b1
`define PCHR_NEXT_RESET 8'h00
`define PCHR_UNMAPPED_DATA 32'h00000000
`endif

// ### pchr_pkg.sv
/*
  Types shared by the capability header register bank.
  Assumes pchr_cfg.svh is on the include path.
*/
package pchr_pkg;
  typedef enum logic [1:0] {
    PCHR_IDLE,
    PCHR_ANSWER
  } pchr_bus_state_e;
  typedef logic [11:0] pchr_addr_t;
endpackage

// ### pchr_fields_if.sv
/*
  Interface carrying the writable capability fields between the bank
  and its read-data assembler.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface pchr_fields_if;
  logic [7:0] next_link;
  logic [3:0] version;
  logic slot;
  logic [2:0] payload_code;
  logic long_tag;
  modport bank (output next_link, output version, output slot, output payload_code,
    output long_tag);
  modport view (input next_link, input version, input slot, input payload_code,
    input long_tag);
endinterface

// ### pchr_read_mux.sv
/*
  Assembles the read image of both capability registers.
  Assumes field values come from the bank over pchr_fields_if.
*/
`timescale 1ns/1ps
`include "pchr_cfg.svh"
module pchr_read_mux
  import pchr_pkg::*;
#(
  parameter logic UPSTREAM = 1'b1
) (
  pchr_fields_if.view fields,
  input wire pchr_addr_t addr_i,
  output logic [31:0] data_o,
  output logic hit_o
);
  wire [3:0] port_type = UPSTREAM ? `PCHR_TYPE_UP : `PCHR_TYPE_DOWN;
  // Reserved bits 31:30 and vector index 29:25 read zero
  wire [31:0] hdr_image = {2'h0, 5'h00, fields.slot, port_type, fields.version,
    fields.next_link, `PCHR_CAPABILITY_IDENTIFIER_VALUE};
  // Flags 13:12, latencies 11:6, phantom 4:3 hardwired zero
  wire [31:0] dcap_image = {18'h00000, 1'b0, 1'b0, 3'h0, 3'h0, fields.long_tag,
    2'h0, fields.payload_code};
  wire hit_hdr = addr_i == `PCHR_HDR_OFFSET;
  wire hit_dcap = addr_i == `PCHR_DCAP_OFFSET;
  assign hit_o = hit_hdr | hit_dcap;
  assign data_o = hit_hdr ? hdr_image : (hit_dcap ? dcap_image : `PCHR_UNMAPPED_DATA);
endmodule

// ### pchr_payload_decode.sv
/*
  Decodes the max payload code into the effective payload in bytes.
  Assumes a purely combinational context.
*/
`timescale 1ns/1ps
module pchr_payload_decode (
  input wire logic [2:0] code_i,
  output logic [12:0] bytes_o
);
  function automatic logic [12:0] payload_bytes(input logic [2:0] code);
    logic [12:0] result;
    result = 13'h0080;
    // Reserved codes fall back to the smallest payload
    if (code <= 3'h5) begin
      result = 13'h0080 << code;
    end
    return result;
  endfunction
  assign bytes_o = payload_bytes(code_i);
endmodule

// ### pchr_regs.sv
/*
  Capability header and device capabilities register bank, reached over
  Avalon-MM with waitrequest; also reports the effective max payload.
  Assumes synchronous inputs on CORE_CLK_I and a synchronous high reset.
*/
// Contract
// - Capability identifier bits 7:0 read-only, always 0x10.
// - Bits 15:8 hold the writable next capability link.
// - Structure version bits 19:16 writable, resets to 0x2.
// - Port type bits 23:20 read 0x5 upstream, 0x6 downstream.
// - Slot bit 24 resets 0; software keeps it zero on upstream port.
// - Vector index bits 29:25 read zero.
// - Max payload code bits 2:0 reset 0x4, codes 0-5 mean 128-4096 bytes.
// - Reserved payload codes 6 and 7 behave as 128 bytes.
// - Phantom function bits 4:3 hardwired zero.
// - Long tag bit 5 writable, resets to 1.
// - Standby latency bits 8:6 hardwired zero.
// - Sleep latency bits 11:9 hardwired zero.
// - Attention button flag bit 12 reads zero.
// - Attention lamp flag bit 13 reads zero.
`timescale 1ns/1ps
`include "pchr_cfg.svh"
module pchr_regs
  import pchr_pkg::*;
#(
  parameter logic UPSTREAM = 1'b1
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CLK_EN_I,
  input wire logic [11:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic [1:0] AVS_RESPONSE_O,
  output logic [12:0] MAX_PAYLOAD_BYTES_O
);
  pchr_fields_if fields ();
  pchr_bus_state_e state;
  logic [7:0] next_link;
  logic [3:0] version;
  logic slot;
  logic [2:0] payload_code;
  logic long_tag;
  wire [31:0] read_image;
  wire read_hit;
  wire [12:0] payload_bytes;
  wire request = AVS_READ_I | AVS_WRITE_I;
  wire in_idle = state == PCHR_IDLE;
  wire accept = CLK_EN_I & in_idle & request;
  wire wr_hdr = accept & AVS_WRITE_I & (AVS_ADDRESS_I == `PCHR_HDR_OFFSET);
  wire wr_dcap = accept & AVS_WRITE_I & (AVS_ADDRESS_I == `PCHR_DCAP_OFFSET);
  wire [31:0] wd = AVS_WRITEDATA_I;
  wire [3:0] be = AVS_BYTEENABLE_I;
  // Only the writable fields are loaded; everything else is never stored
  wire [7:0] next_next_link = (wr_hdr & be[1]) ? wd[15:8] : next_link;
  wire [3:0] next_version = (wr_hdr & be[2]) ? wd[19:16] : version;
  wire next_slot = (wr_hdr & be[3]) ? wd[`PCHR_SLOT_BIT] : slot;
  wire [2:0] next_payload_code = (wr_dcap & be[0]) ? wd[2:0] : payload_code;
  wire next_long_tag = (wr_dcap & be[0]) ? wd[`PCHR_TAG_BIT] : long_tag;
  assign fields.next_link = next_link;
  assign fields.version = version;
  assign fields.slot = slot;
  assign fields.payload_code = payload_code;
  assign fields.long_tag = long_tag;
  pchr_read_mux #(
    .UPSTREAM(UPSTREAM)
  ) u_read_mux (
    .fields(fields.view),
    .addr_i(AVS_ADDRESS_I),
    .data_o(read_image),
    .hit_o(read_hit)
  );
  pchr_payload_decode u_payload (
    .code_i(payload_code),
    .bytes_o(payload_bytes)
  );
  // Writable fields
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      next_link <= `PCHR_NEXT_RESET;
      version <= `PCHR_VER_RESET;
      slot <= `PCHR_SLOT_RESET;
      payload_code <= `PCHR_MPS_RESET;
      long_tag <= `PCHR_TAG_RESET;
    end else if (CLK_EN_I) begin
      next_link <= next_next_link;
      version <= next_version;
      slot <= next_slot;
      payload_code <= next_payload_code;
      long_tag <= next_long_tag;
    end
  end
  // One-wait answer: waitrequest drops the cycle after the request is seen
  wire next_wait = ~(accept);
  wire [1:0] next_resp = read_hit ? 2'h0 : 2'h3;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state <= PCHR_IDLE;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h00000000;
      AVS_RESPONSE_O <= 2'h0;
      MAX_PAYLOAD_BYTES_O <= 13'h0000;
    end else if (CLK_EN_I) begin
      state <= accept ? PCHR_ANSWER : PCHR_IDLE;
      AVS_WAITREQUEST_O <= next_wait;
      if (accept) begin
        AVS_READDATA_O <= AVS_READ_I ? read_image : 32'h00000000;
        AVS_RESPONSE_O <= next_resp;
      end
      MAX_PAYLOAD_BYTES_O <= payload_bytes;
    end
  end
endmodule

// ### pchr_regs_sva.sv
/*
  Port assertions for the capability register bank.
  Assumes binding onto pchr_regs from the bench top.
*/
`timescale 1ns/1ps
module pchr_regs_sva #(
  parameter logic UPSTREAM = 1'b1
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CLK_EN_I,
  input wire logic [11:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [1:0] AVS_RESPONSE_O,
  input wire logic [12:0] MAX_PAYLOAD_BYTES_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  wire logic ans = !AVS_WAITREQUEST_O;
  wire logic req = AVS_READ_I || AVS_WRITE_I;
  wire logic hdr = ans && AVS_READ_I && AVS_ADDRESS_I == 12'h040;
  wire logic dcp = ans && AVS_READ_I && AVS_ADDRESS_I == 12'h044;
  wire logic bad = ans && req && AVS_ADDRESS_I != 12'h040 && AVS_ADDRESS_I != 12'h044;
  a_capability_identifier_fixed: assert property (hdr |-> AVS_READDATA_O[7:0] == 8'h10)
    else $error("capability identifier wrong");
  a_port_type: assert property (
    hdr |-> AVS_READDATA_O[23:20] == (UPSTREAM ? 4'h5 : 4'h6))
    else $error("port type wrong");
  a_vector_zero: assert property (hdr |-> AVS_READDATA_O[31:25] == 7'h00)
    else $error("vector index or reserved bits set");
  a_dcap_fixed: assert property (
    dcp |-> {AVS_READDATA_O[13:6], AVS_READDATA_O[4:3]} == 10'h000)
    else $error("hardwired capability bits set");
  a_payload_map: assert property (dcp |-> MAX_PAYLOAD_BYTES_O ==
    (AVS_READDATA_O[2:0] > 3'h5 ? 13'h080 : 13'h080 << AVS_READDATA_O[2:0]))
    else $error("effective payload does not match code");
  a_unmapped_err: assert property (
    bad |-> AVS_RESPONSE_O == 2'h3 && AVS_READDATA_O == 32'h0)
    else $error("unmapped access not refused");
  a_answer_next: assert property (req && AVS_WAITREQUEST_O && CLK_EN_I |=> ans)
    else $error("request not answered next cycle");
  a_wait_pulse: assert property (ans && CLK_EN_I |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  cover property (hdr);
  cover property (dcp);
  cover property (bad);
  cover property (req && !CLK_EN_I);
endmodule

// ### tb_pcie_capability_header_regs.sv
/*
  Self-checking bench for the capability register bank.
  Assumes the upstream build; drives the Avalon-MM port directly.
*/
`timescale 1ns/1ps
module tb_pcie_capability_header_regs;
  import pchr_pkg::*;
  localparam logic UPSTREAM = 1'b1;
  logic clk = 1'b0, rst = 1'b1, en = 1'b1, rd = 1'b0, wr = 1'b0, sl = 1'b0, tg = 1'b1;
  logic [31:0] wd = 32'h0, rdat;
  logic [3:0] be = 4'h0, vr = 4'h2;
  logic [7:0] nl = 8'h00;
  logic [2:0] pc = 3'h4;
  pchr_addr_t adr = 12'h000;
  pchr_addr_t at [3] = '{12'h040, 12'h044, 12'h0a0};
  wire logic [31:0] rdo;
  wire logic wt;
  wire logic [1:0] rsp;
  wire logic [12:0] pay;
  int error_cnt = 0;
  int checks_done = 0;
  pchr_regs #(.UPSTREAM(UPSTREAM)) pchr_regs_inst (.CORE_CLK_I(clk), .RST_I(rst),
    .CLK_EN_I(en), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdo),
    .AVS_WAITREQUEST_O(wt), .AVS_RESPONSE_O(rsp), .MAX_PAYLOAD_BYTES_O(pay));
  initial forever #12.5 clk = ~clk;
  function logic [31:0] hdr_x();
    return {7'h00, sl, (UPSTREAM ? 4'h5 : 4'h6), vr, nl, 8'h10};
  endfunction
  function logic [31:0] dcap_x();
    return {26'h0, tg, 2'h0, pc};
  endfunction
  function logic [12:0] pay_x(input logic [2:0] c);
    return c > 3'h5 ? 13'h080 : 13'h080 << c;
  endfunction
  task end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Frozen clock enable for f cycles holds the request untaken
  task op(input logic w, input pchr_addr_t a, input logic [31:0] d, input logic [3:0] b,
    input int f);
    int n;
    logic m;
    m = a == 12'h040 || a == 12'h044;
    // Software keeps the slot bit clear on the upstream port
    if (UPSTREAM && a == 12'h040) d[24] = 1'b0;
    @(posedge clk);
    {adr, wr, rd, wd, be, en} <= {a, w, !w, d, b, f == 0};
    for (n = 0; n < f; n++) begin
      @(posedge clk);
      chk(32'(wt), 32'h1);
    end
    if (f > 0) en <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (wt !== 1'b0) begin
      error_cnt++;
      end_of_test();
    end
    rdat = rdo;
    chk(32'(rsp), m ? 32'h0 : 32'h3);
    rd <= 1'b0;
    wr <= 1'b0;
    if (w && a == 12'h040 && b[1]) nl = d[15:8];
    if (w && a == 12'h040 && b[2]) vr = d[19:16];
    if (w && a == 12'h040 && b[3]) sl = d[24];
    if (w && a == 12'h044 && b[0]) {tg, pc} = {d[5], d[2:0]};
    if (!w && a == 12'h040) chk(rdat, hdr_x());
    if (!w && a == 12'h044) chk(rdat, dcap_x());
    if (!w && !m) chk(rdat, 32'h0);
    if (w) chk(rdat, 32'h0);
    @(posedge clk);
    chk(32'(pay), 32'(pay_x(pc)));
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    void'($urandom(5));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    op(1'b0, 12'h040, 32'h0, 4'h0, 0);
    op(1'b0, 12'h044, 32'h0, 4'h0, 1);
    op(1'b1, 12'h040, 32'hffffffff, 4'hf, 0);
    op(1'b0, 12'h040, 32'h0, 4'h0, 0);
    op(1'b1, 12'h044, 32'hffffffff, 4'hf, 2);
    op(1'b0, 12'h044, 32'h0, 4'h0, 0);
    // Mid-run reset must bring every writable field back to its default
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    {nl, vr, sl, tg, pc} = {8'h00, 4'h2, 1'b0, 1'b1, 3'h4};
    op(1'b0, 12'h040, 32'h0, 4'h0, 0);
    op(1'b0, 12'h044, 32'h0, 4'h0, 0);
    op(1'b1, 12'h048, 32'h1, 4'hf, 0);
    op(1'b0, 12'hffc, 32'h0, 4'h0, 0);
    for (int c = 0; c < 8; c++) begin
      op(1'b1, 12'h044, {26'h0, c[0], 2'h0, c[2:0]}, 4'h1, 0);
      op(1'b0, 12'h044, 32'h0, 4'h0, 0);
    end
    for (int i = 0; i < 40; i++) begin
      op(1'($urandom), at[$urandom % 3], $urandom, 4'($urandom), $urandom % 3);
    end
    end_of_test();
  end
endmodule
bind pchr_regs pchr_regs_sva #(.UPSTREAM(UPSTREAM)) pchr_regs_sva_inst (.CORE_CLK_I(CORE_CLK_I),
  .RST_I(RST_I), .CLK_EN_I(CLK_EN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .AVS_RESPONSE_O(AVS_RESPONSE_O),
  .MAX_PAYLOAD_BYTES_O(MAX_PAYLOAD_BYTES_O));
